/* File: include/irq_pc_pkg.sv */
// Shared constants and types for the interrupt gating and program counter unit
package irq_pc_pkg;

  // Bus geometry
  localparam int          AXI_ADDR_W         = 12;
  localparam int          AXI_DATA_W         = 32;
  localparam int          IDX_LSB            = 2;
  localparam int          IDX_MSB            = 9;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_PC_LOW         = 8'h02;
  localparam logic [7:0]  IDX_PC_HIGH_LATCH  = 8'h0A;
  localparam logic [7:0]  IDX_IRQ_CONTROL    = 8'h0B;
  localparam logic [7:0]  IDX_PERIPH_FLAGS   = 8'h0C;
  localparam logic [7:0]  IDX_IRQ_CONTROL_B1 = 8'h8B;
  localparam logic [7:0]  IDX_PERIPH_ENABLES = 8'h8C;
  localparam logic [7:0]  IDX_EDGE_CONTROL   = 8'h90;

  // Interrupt control field positions
  localparam int          GLOBAL_EN_BIT      = 7;
  localparam int          PERIPH_EN_BIT      = 6;
  localparam int          TIMER_EN_BIT       = 5;
  localparam int          EXT_EN_BIT         = 4;
  localparam int          CHANGE_EN_BIT      = 3;
  localparam int          TIMER_FLAG_BIT     = 2;
  localparam int          EXT_FLAG_BIT       = 1;
  localparam int          CHANGE_FLAG_BIT    = 0;
  localparam int          CONVERTER_BIT      = 6;
  localparam int          EDGE_SELECT_BIT    = 0;

  // Reset values
  localparam logic [7:0]  IRQ_CONTROL_RST    = 8'h00;
  localparam logic        CONVERTER_RST      = 1'b0;
  localparam logic [4:0]  HIGH_LATCH_RST     = 5'h00;
  localparam logic        EDGE_SELECT_RST    = 1'b1;
  localparam logic [12:0] PC_RST             = 13'h0000;

  // Program counter and stack geometry
  localparam int          PC_W               = 13;
  localparam int          TARGET_W           = 11;
  localparam int          LATCH_W            = 5;
  localparam int          STACK_DEPTH        = 8;
  localparam int          CHANGE_PINS        = 3;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY          = 2'b00;
  localparam logic [1:0]  RESP_SLVERR        = 2'b10;

  // Sequencer commands
  typedef enum logic [2:0] {
    SEQ_NONE       = 3'b000,
    SEQ_ADVANCE    = 3'b001,
    SEQ_JUMP       = 3'b010,
    SEQ_CALL       = 3'b011,
    SEQ_RETURN     = 3'b100,
    SEQ_IRQ_BRANCH = 3'b101
  } seq_op_type;

  typedef struct packed {
    seq_op_type          op;
    logic [TARGET_W-1:0] target;
  } seq_cmd_type;

  // One-cycle event pulses from on-chip sources
  typedef struct packed {
    logic timer_overflow;
    logic converter_done;
  } irq_event_type;

endpackage : irq_pc_pkg

/* File: hw/return_stack.sv */
// Eight-entry circular return address stack
`timescale 1ns/1ps
`default_nettype none

module return_stack
  import irq_pc_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = PC_W
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             push,
  input  wire logic             pop,
  input  wire logic [WIDTH-1:0] push_data,
  output logic      [WIDTH-1:0] top_value
);

  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0]            ptr;
  } stack_state_type;

  stack_state_type state_reg;
  stack_state_type state_next;

  ////////////////////////////////////////////////////////////////////////////
  // Next state; pointer wraps silently, no overflow or underflow status
  always_comb begin
    state_next = state_reg;
    if (push) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (state_reg.ptr == PTR_W'(i)) begin
          state_next.mem[i] = push_data;
        end
      end
      state_next.ptr = state_reg.ptr + 1'b1;
    end else if (pop) begin
      state_next.ptr = state_reg.ptr - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Most recent entry; after excess pops this is simply an older slot
  assign top_value = state_reg.mem[PTR_W'(state_reg.ptr - 1'b1)];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_push_wraps_round: assert property (@(posedge clk) disable iff (rst)
    push && state_reg.ptr == PTR_W'(DEPTH - 1) |=> state_reg.ptr == '0)
    else $error("stack pointer did not wrap after last slot");

  a_push_then_top: assert property (@(posedge clk) disable iff (rst)
    push |=> top_value == $past(push_data))
    else $error("pushed value not on top of stack");

endmodule : return_stack

`default_nettype wire

/* File: hw/irq_gating_pc_stack.sv */
// Interrupt gating, program counter and return stack with an AXI4-Lite slave
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - interrupt control register at two indices; enables bits 7..3, flags bits 2..0
// - each flag sets on its condition regardless of any enable bit
// - peripheral interrupts need the peripheral enable bit besides their own enable
// - peripheral enable register holds only converter-done enable at bit 6
// - peripheral flag register holds peripheral source flags at its own index
// - call or accepted interrupt branch pushes the current program counter
// - program counter is 13 bits; only low byte is software visible
// - writing the low byte loads upper bits from high latch bits 4..0
// - call or jump takes latch bits 4..3; instruction gives the rest
// - reset clears the whole program counter
// - return stack has eight 13-bit entries outside program and data space
// - stack pointer has no software access of any kind
// - plain return, literal return and interrupt return pop into the counter
// - push and pop leave the high latch unchanged
// - stack is circular; ninth push overwrites the first entry
// - no overflow or underflow status; wrap and excess pops are silent
// - external flag sets on rising edge if select is one, else falling
// - pin-change flag follows any change on the three change pins
module irq_gating_pc_stack
  import irq_pc_pkg::*;
#(
  parameter logic [PC_W-1:0] IRQ_VECTOR = 13'h0004
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [AXI_ADDR_W-1:0]  awaddr,
  input  wire logic                   awvalid,
  output logic                        awready,
  input  wire logic [AXI_DATA_W-1:0]  wdata,
  input  wire logic [3:0]             wstrb,
  input  wire logic                   wvalid,
  output logic                        wready,
  output logic [1:0]                  bresp,
  output logic                        bvalid,
  input  wire logic                   bready,
  input  wire logic [AXI_ADDR_W-1:0]  araddr,
  input  wire logic                   arvalid,
  output logic                        arready,
  output logic [AXI_DATA_W-1:0]       rdata,
  output logic [1:0]                  rresp,
  output logic                        rvalid,
  input  wire logic                   rready,
  input  wire seq_cmd_type            seq_cmd,
  input  wire irq_event_type          irq_events,
  input  wire logic                   ext_pin,
  input  wire logic [CHANGE_PINS-1:0] pin_change_pins,
  output logic [PC_W-1:0]             pc_value,
  output logic                        irq_request
);

  typedef struct packed {
    logic [7:0]             irq_control;
    logic                   converter_done_irq_enable;
    logic                   converter_done_flag;
    logic [LATCH_W-1:0]     pc_high_latch;
    logic                   ext_edge_select;
    logic [PC_W-1:0]        pc;
    logic [2:0]             ext_sync;
    logic [CHANGE_PINS-1:0] chg_sync1;
    logic [CHANGE_PINS-1:0] chg_sync2;
    logic [CHANGE_PINS-1:0] chg_prev;
    logic                   aw_held;
    logic [7:0]             aw_idx;
    logic                   aw_ok;
    logic                   w_held;
    logic [7:0]             w_data;
    logic                   w_lane0;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [7:0]             rdata;
    logic [1:0]             rresp;
  } state_type;

  state_type       state_reg;
  state_type       state_next;
  logic            wr_fire;
  logic            wr_do;
  logic            pcl_write;
  logic            ext_event;
  logic            change_event;
  logic            stack_push;
  logic            stack_pop;
  logic [PC_W-1:0] stack_top;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode helpers

  // Mapped register index, aligned word inside the 1 KiB window
  function automatic logic addr_ok(input logic [AXI_ADDR_W-1:0] addr);
    logic [7:0] idx;
    logic       hit;
    idx = addr[IDX_MSB:IDX_LSB];
    hit = 1'b0;
    if (idx == IDX_PC_LOW) begin
      hit = 1'b1;
    end else if (idx == IDX_PC_HIGH_LATCH) begin
      hit = 1'b1;
    end else if (idx == IDX_IRQ_CONTROL || idx == IDX_IRQ_CONTROL_B1) begin
      hit = 1'b1;
    end else if (idx == IDX_PERIPH_FLAGS || idx == IDX_PERIPH_ENABLES) begin
      hit = 1'b1;
    end else if (idx == IDX_EDGE_CONTROL) begin
      hit = 1'b1;
    end
    return hit && addr[AXI_ADDR_W-1:IDX_MSB+1] == '0 && addr[IDX_LSB-1:0] == '0;
  endfunction : addr_ok

  // Read value; the stack pointer is deliberately never mapped
  function automatic logic [7:0] read_mux(input state_type s, input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == IDX_PC_LOW) begin
      v = s.pc[7:0];
    end else if (idx == IDX_PC_HIGH_LATCH) begin
      v = {3'b000, s.pc_high_latch};
    end else if (idx == IDX_IRQ_CONTROL || idx == IDX_IRQ_CONTROL_B1) begin
      v = s.irq_control;
    end else if (idx == IDX_PERIPH_FLAGS) begin
      v[CONVERTER_BIT] = s.converter_done_flag;
    end else if (idx == IDX_PERIPH_ENABLES) begin
      v[CONVERTER_BIT] = s.converter_done_irq_enable;
    end else if (idx == IDX_EDGE_CONTROL) begin
      v[EDGE_SELECT_BIT] = s.ext_edge_select;
    end
    return v;
  endfunction : read_mux

  ////////////////////////////////////////////////////////////////////////////
  // Event detection on synchronised pins
  always_comb begin
    ext_event = state_reg.ext_edge_select ?
                (state_reg.ext_sync[1] & ~state_reg.ext_sync[2]) :
                (~state_reg.ext_sync[1] & state_reg.ext_sync[2]);
    change_event = |(state_reg.chg_sync2 ^ state_reg.chg_prev);
  end

  // Bus handshakes; address and data are taken independently
  assign awready = ~state_reg.aw_held & ~state_reg.bvalid;
  assign wready  = ~state_reg.w_held & ~state_reg.bvalid;
  assign arready = ~state_reg.rvalid;
  assign wr_fire = state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid;
  assign wr_do   = wr_fire & state_reg.aw_ok & state_reg.w_lane0;
  assign pcl_write = wr_do && state_reg.aw_idx == IDX_PC_LOW;

  // Stack control from the sequencer
  assign stack_push = seq_cmd.op == SEQ_CALL || seq_cmd.op == SEQ_IRQ_BRANCH;
  assign stack_pop  = seq_cmd.op == SEQ_RETURN;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    state_next = state_reg;

    // Two-stage synchronisers, then one history stage for edges
    state_next.ext_sync  = {state_reg.ext_sync[1], state_reg.ext_sync[0], ext_pin};
    state_next.chg_sync1 = pin_change_pins;
    state_next.chg_sync2 = state_reg.chg_sync1;
    state_next.chg_prev  = state_reg.chg_sync2;

    // Write address and data capture
    if (awvalid && awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_idx  = awaddr[IDX_MSB:IDX_LSB];
      state_next.aw_ok   = addr_ok(awaddr);
    end
    if (wvalid && wready) begin
      state_next.w_held  = 1'b1;
      state_next.w_data  = wdata[7:0];
      state_next.w_lane0 = wstrb[0];
    end

    // Response once both halves are in
    if (wr_fire) begin
      state_next.aw_held = 1'b0;
      state_next.w_held  = 1'b0;
      state_next.bvalid  = 1'b1;
      state_next.bresp   = state_reg.aw_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end

    // Register writes; the latch only ever changes here
    if (wr_do) begin
      if (state_reg.aw_idx == IDX_PC_HIGH_LATCH) begin
        state_next.pc_high_latch = state_reg.w_data[LATCH_W-1:0];
      end else if (state_reg.aw_idx == IDX_IRQ_CONTROL ||
                   state_reg.aw_idx == IDX_IRQ_CONTROL_B1) begin
        state_next.irq_control = state_reg.w_data;
      end else if (state_reg.aw_idx == IDX_PERIPH_FLAGS) begin
        state_next.converter_done_flag = state_reg.w_data[CONVERTER_BIT];
      end else if (state_reg.aw_idx == IDX_PERIPH_ENABLES) begin
        state_next.converter_done_irq_enable = state_reg.w_data[CONVERTER_BIT];
      end else if (state_reg.aw_idx == IDX_EDGE_CONTROL) begin
        state_next.ext_edge_select = state_reg.w_data[EDGE_SELECT_BIT];
      end
    end

    // Events set flags after software writes, so a set beats a clear
    if (irq_events.timer_overflow) begin
      state_next.irq_control[TIMER_FLAG_BIT] = 1'b1;
    end
    if (ext_event) begin
      state_next.irq_control[EXT_FLAG_BIT] = 1'b1;
    end
    if (change_event) begin
      state_next.irq_control[CHANGE_FLAG_BIT] = 1'b1;
    end
    if (irq_events.converter_done) begin
      state_next.converter_done_flag = 1'b1;
    end

    // Program counter; sequencer commands take priority over a low-byte write
    case (seq_cmd.op)
      SEQ_ADVANCE: begin
        state_next.pc = state_reg.pc + 13'h0001;
      end
      SEQ_JUMP, SEQ_CALL: begin
        state_next.pc = {state_reg.pc_high_latch[4:3], seq_cmd.target};
      end
      SEQ_RETURN: begin
        state_next.pc = stack_top;
      end
      SEQ_IRQ_BRANCH: begin
        state_next.pc = IRQ_VECTOR;
      end
      default: begin
        if (pcl_write) begin
          // No carry out of the low byte; upper bits always from the latch
          state_next.pc = {state_reg.pc_high_latch, state_reg.w_data};
        end
      end
    endcase

    // Read channel, answered one cycle after the address is taken
    if (arvalid && arready) begin
      state_next.rvalid = 1'b1;
      state_next.rdata  = addr_ok(araddr) ? read_mux(state_reg, araddr[IDX_MSB:IDX_LSB]) : 8'h00;
      state_next.rresp  = addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
    end
  end

  // State register; every reset clears the counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg                           <= '0;
      state_reg.irq_control               <= IRQ_CONTROL_RST;
      state_reg.converter_done_irq_enable <= CONVERTER_RST;
      state_reg.converter_done_flag       <= CONVERTER_RST;
      state_reg.pc_high_latch             <= HIGH_LATCH_RST;
      state_reg.ext_edge_select           <= EDGE_SELECT_RST;
      state_reg.pc                        <= PC_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Return stack; its pointer has no port toward the bus
  return_stack #(
    .DEPTH (STACK_DEPTH),
    .WIDTH (PC_W)
  ) u_stack (
    .clk       (clk),
    .rst       (rst),
    .push      (stack_push),
    .pop       (stack_pop),
    .push_data (state_reg.pc),
    .top_value (stack_top)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign bvalid   = state_reg.bvalid;
  assign bresp    = state_reg.bresp;
  assign rvalid   = state_reg.rvalid;
  assign rresp    = state_reg.rresp;
  assign rdata    = {24'h000000, state_reg.rdata};
  assign pc_value = state_reg.pc;

  // Request gating; peripheral sources pass an extra enable
  assign irq_request = state_reg.irq_control[GLOBAL_EN_BIT] & (
      (state_reg.irq_control[TIMER_EN_BIT]  & state_reg.irq_control[TIMER_FLAG_BIT])  |
      (state_reg.irq_control[EXT_EN_BIT]    & state_reg.irq_control[EXT_FLAG_BIT])    |
      (state_reg.irq_control[CHANGE_EN_BIT] & state_reg.irq_control[CHANGE_FLAG_BIT]) |
      (state_reg.irq_control[PERIPH_EN_BIT] & state_reg.converter_done_irq_enable &
       state_reg.converter_done_flag));

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_pc_after_reset: assert property (@(posedge clk) disable iff (rst)
    $past(rst) |-> pc_value == PC_RST)
    else $error("program counter not zero after reset");

  a_low_byte_load: assert property (@(posedge clk) disable iff (rst)
    pcl_write && seq_cmd.op == SEQ_NONE |=>
      pc_value == {$past(state_reg.pc_high_latch), $past(state_reg.w_data)})
    else $error("low byte write loaded wrong counter value");

  a_jump_upper_bits: assert property (@(posedge clk) disable iff (rst)
    seq_cmd.op == SEQ_JUMP |=>
      pc_value == {$past(state_reg.pc_high_latch[4:3]), $past(seq_cmd.target)})
    else $error("jump did not take latch bits 4 and 3");

  a_call_return_pair: assert property (@(posedge clk) disable iff (rst)
    seq_cmd.op == SEQ_CALL ##1 seq_cmd.op == SEQ_RETURN |=> pc_value == $past(pc_value, 2))
    else $error("return did not restore pushed counter");

  a_latch_kept_stack: assert property (@(posedge clk) disable iff (rst)
    (stack_push || stack_pop) && !wr_do |=> $stable(state_reg.pc_high_latch))
    else $error("stack operation disturbed the high latch");

  a_timer_flag_sets: assert property (@(posedge clk) disable iff (rst)
    irq_events.timer_overflow |=> state_reg.irq_control[TIMER_FLAG_BIT])
    else $error("timer event did not set its flag");

  a_global_blocks: assert property (@(posedge clk) disable iff (rst)
    !state_reg.irq_control[GLOBAL_EN_BIT] |-> !irq_request)
    else $error("request raised with global enable clear");

  a_periph_gated: assert property (@(posedge clk) disable iff (rst)
    !state_reg.irq_control[PERIPH_EN_BIT] &&
    !(state_reg.irq_control[TIMER_EN_BIT] && state_reg.irq_control[TIMER_FLAG_BIT]) &&
    !(state_reg.irq_control[EXT_EN_BIT] && state_reg.irq_control[EXT_FLAG_BIT]) &&
    !(state_reg.irq_control[CHANGE_EN_BIT] && state_reg.irq_control[CHANGE_FLAG_BIT])
      |-> !irq_request)
    else $error("peripheral request passed without peripheral enable");

  a_ext_rising_flag: assert property (@(posedge clk) disable iff (rst)
    state_reg.ext_edge_select && state_reg.ext_sync[1] && !state_reg.ext_sync[2]
      |=> state_reg.irq_control[EXT_FLAG_BIT])
    else $error("rising edge did not set external flag");

  a_enable_reads_zero: assert property (@(posedge clk) disable iff (rst)
    arvalid && arready && araddr == AXI_ADDR_W'({IDX_PERIPH_ENABLES, 2'b00})
      |=> rvalid && rdata[7] == 1'b0 && rdata[5:0] == 6'h00)
    else $error("unimplemented enable bits read nonzero");

  a_bvalid_holds: assert property (@(posedge clk) disable iff (rst)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

endmodule : irq_gating_pc_stack

`default_nettype wire

/* File: bench/seq_source_model.sv */
// Sequencer and interrupt source model facing the unit
`timescale 1ns/1ps
`default_nettype none

module seq_source_model
  import irq_pc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire seq_cmd_type   cmd_req,
  input  wire irq_event_type ev_req,
  output var  seq_cmd_type   seq_cmd,
  output var  irq_event_type irq_events
);
  // One op per cycle; a request is shown one cycle late and held for as long as it is given
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      seq_cmd    <= '0;
      irq_events <= '0;
    end else begin
      seq_cmd    <= cmd_req;
      irq_events <= ev_req;
    end
  end
endmodule : seq_source_model

`default_nettype wire

/* File: bench/test_irq_gating_pc_stack.sv */
// Self-checking bench for the interrupt gating and program counter unit
`timescale 1ns/1ps
`default_nettype none

module test_irq_gating_pc_stack
  import irq_pc_pkg::*;
;
  logic          clk, rst, awvalid, wvalid, bready, arvalid, rready, ext_pin;
  logic          awready, wready, bvalid, arready, rvalid, irq_request;
  logic [11:0]   awaddr, araddr;
  logic [31:0]   wdata, rdata;
  logic [3:0]    wstrb;
  logic [1:0]    bresp, rresp, resp;
  logic [2:0]    pin_change_pins;
  logic [12:0]   pc_value;
  seq_cmd_type   cmd_req, seq_cmd;
  irq_event_type ev_req, irq_events;
  int            fail_count, n_checks;

  irq_gating_pc_stack i_dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .seq_cmd(seq_cmd), .irq_events(irq_events), .ext_pin(ext_pin),
    .pin_change_pins(pin_change_pins), .pc_value(pc_value), .irq_request(irq_request));

  seq_source_model i_src (.clk(clk), .rst(rst), .cmd_req(cmd_req), .ev_req(ev_req),
    .seq_cmd(seq_cmd), .irq_events(irq_events));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // Write and address offered together, each dropped once taken
  task automatic bus_write(input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (n == 40) begin
      fail_count++;
      complete_run();
    end
  endtask : bus_write

  // Read one word; rdata and rresp taken at the handshake edge
  task automatic bus_read(input logic [11:0] a, output logic [31:0] d);
    int n;
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (n == 40) begin
      fail_count++;
      complete_run();
    end
  endtask : bus_read

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] d;
    bus_read(a, d);
    check(what, {24'h000000, exp}, d);
    check("rresp", 32'(RESP_OKAY), 32'(resp));
  endtask : rd_chk

  // Hand one op and event pulse to the model; pc settles two edges later
  task automatic apply(input seq_op_type op, input logic [10:0] t, input irq_event_type e);
    @(posedge clk);
    cmd_req <= '{op, t};
    ev_req  <= e;
    @(posedge clk);
    cmd_req <= '{SEQ_NONE, 11'h000};
    ev_req  <= 2'b00;
    @(posedge clk);
    #1;
  endtask : apply

  ////////////////////////////////////////////////////////////////
  // Flag setting, request gating and both control indices
  task automatic irq_flags_scn();
    rd_chk("irq_control", 12'h02C, 8'h00);
    apply(SEQ_NONE, 11'h000, 2'b10);
    rd_chk("timer_flag", 12'h02C, 8'h04);
    check("irq_masked", 32'h0, 32'(irq_request));
    bus_write(12'h22C, 8'hA4);
    check("alias_wresp", 32'(RESP_OKAY), 32'(resp));
    check("irq_timer", 32'h1, 32'(irq_request));
    rd_chk("irq_alias", 12'h02C, 8'hA4);
    bus_write(12'h02C, 8'h00);
    apply(SEQ_NONE, 11'h000, 2'b01);
    rd_chk("periph_flags", 12'h030, 8'h40);
    bus_write(12'h230, 8'hFF);
    rd_chk("periph_enables", 12'h230, 8'h40);
    bus_write(12'h02C, 8'h80);
    check("irq_no_periph", 32'h0, 32'(irq_request));
    bus_write(12'h02C, 8'hC0);
    check("irq_periph", 32'h1, 32'(irq_request));
    bus_write(12'h030, 8'h00);
    bus_write(12'h02C, 8'h00);
  endtask : irq_flags_scn

  // Pin edges reach the flags through the synchronisers
  task automatic pin_events_scn();
    @(posedge clk);
    ext_pin         <= 1'b1;
    pin_change_pins <= 3'b100;
    repeat (6) @(posedge clk);
    rd_chk("rise_and_change", 12'h02C, 8'h03);
    bus_write(12'h240, 8'h00);
    bus_write(12'h02C, 8'h00);
    ext_pin <= 1'b0;
    repeat (6) @(posedge clk);
    rd_chk("fall_flag", 12'h02C, 8'h02);
    bus_write(12'h02C, 8'h00);
  endtask : pin_events_scn

  // Low byte load, circular stack, interrupt branch, unmapped index
  task automatic pc_stack_scn();
    int          i;
    logic [31:0] d;
    bus_write(12'h028, 8'h15);
    bus_write(12'h008, 8'h34);
    check("pc_low_write", 32'h1534, 32'(pc_value));
    rd_chk("pc_low", 12'h008, 8'h34);
    // Nine calls: the ninth lands on the slot of the first
    for (i = 1; i <= 9; i++) begin
      apply(SEQ_CALL, 11'(3 * i), 2'b00);
      check("pc_call", 32'h1000 + 32'(3 * i), 32'(pc_value));
    end
    for (i = 8; i >= 0; i--) begin
      apply(SEQ_RETURN, 11'h000, 2'b00);
      check("pc_return", 32'h1000 + 32'(3 * (i == 0 ? 8 : i)), 32'(pc_value));
    end
    rd_chk("latch_kept", 12'h028, 8'h15);
    apply(SEQ_IRQ_BRANCH, 11'h000, 2'b00);
    check("pc_vector", 32'h0004, 32'(pc_value));
    apply(SEQ_RETURN, 11'h000, 2'b00);
    check("pc_irq_return", 32'h1018, 32'(pc_value));
    bus_read(12'h3FC, d);
    check("unmapped_resp", 32'(RESP_SLVERR), 32'(resp));
    check("unmapped_data", 32'h0, d);
    bus_write(12'h3FC, 8'h5A);
    check("unmapped_wresp", 32'(RESP_SLVERR), 32'(resp));
  endtask : pc_stack_scn

  // Jump, advance, a return on the op right after a call, lane off
  task automatic seq_ops_scn();
    apply(SEQ_JUMP, 11'h2AA, 2'b00);
    check("pc_jump", 32'h12AA, 32'(pc_value));
    apply(SEQ_ADVANCE, 11'h000, 2'b00);
    check("pc_advance", 32'h12AB, 32'(pc_value));
    @(posedge clk);
    cmd_req <= '{SEQ_CALL, 11'h055};
    @(posedge clk);
    cmd_req <= '{SEQ_RETURN, 11'h000};
    @(posedge clk);
    cmd_req <= '{SEQ_NONE, 11'h000};
    @(posedge clk);
    #1;
    check("pc_pair_return", 32'h12AB, 32'(pc_value));
    wstrb <= 4'h0;
    bus_write(12'h008, 8'h77);
    check("lane_off_wresp", 32'(RESP_OKAY), 32'(resp));
    check("lane_off_pc", 32'h12AB, 32'(pc_value));
    wstrb <= 4'hF;
  endtask : seq_ops_scn

  // Reset in mid-run from a nonzero counter; pins idle so no false edge
  task automatic mid_reset_scn();
    @(posedge clk);
    rst             <= 1'b1;
    pin_change_pins <= 3'b000;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("pc_mid_reset", 32'h0, 32'(pc_value));
    rd_chk("pc_low_reset", 12'h008, 8'h00);
  endtask : mid_reset_scn

  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, ext_pin} = 6'h00;
    {awaddr, araddr, wdata, pin_change_pins} = '0;
    wstrb   = 4'hF;
    cmd_req = '0;
    ev_req  = '0;
    rst     = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check("pc_reset", 32'h0, 32'(pc_value));
    irq_flags_scn();
    pin_events_scn();
    pc_stack_scn();
    seq_ops_scn();
    mid_reset_scn();
    complete_run();
  end
endmodule : test_irq_gating_pc_stack

`default_nettype wire
